//--- bench/pcache_cpu_model.sv
// Processor fetch and load path model feeding the cache statistics.
// Assumes tasks are called right after a rising clock edge.
`timescale 1ns/10ps
module pcache_cpu_model
(
  input  wire logic                pclk,          // Clock.
  output pcache_pkg::cpu_access_t  cpu_acc,       // Access bundle.
  output logic                     prefetch_abort // Abort pulse.
);
  // ==========================================================================
  // Idle state at time zero.
  initial
  begin
    cpu_acc = '0;
    prefetch_abort = 1'b0;
  end
  // One access; the idle bus then shows inverted fields, not stale ones.
  task automatic acc(input logic f, input logic c, input logic [19:0] t);
    cpu_acc <= {1'b1, f, c, t};
    @(posedge pclk);
    cpu_acc <= {1'b0, ~f, ~c, ~t};
    @(posedge pclk);
  endtask : acc
  // One abandoned prefetch pulse.
  task automatic abort_pf();
    prefetch_abort <= 1'b1;
    @(posedge pclk);
    prefetch_abort <= 1'b0;
    @(posedge pclk);
  endtask : abort_pf
endmodule : pcache_cpu_model

//--- bench/pcache_line_stats_checker.sv
// Port checker for the cache line access and statistics block.
// Assumes it is bound onto the top module; one clock, async reset.
`timescale 1ns/10ps
module pcache_line_stats_checker
(
  input wire logic                    pclk,           // Clock.
  input wire logic                    presetn,        // Reset, low.
  input wire logic                    psel,           // Select.
  input wire logic                    penable,        // Enable.
  input wire logic                    pwrite,         // Direction.
  input wire logic [7:0]              paddr,          // Address.
  input wire logic [31:0]             pwdata,         // Write data.
  input wire logic [31:0]             prdata,         // Read data.
  input wire logic                    pready,         // Ready.
  input wire logic                    pslverr,        // Error.
  input wire pcache_pkg::cpu_access_t cpu_acc,        // Access.
  input wire logic                    prefetch_abort, // Abort pulse.
  input wire logic                    code_protect,   // Protection.
  input wire logic [24:0]             lru_state,      // LRU state.
  input wire logic                    hit_r,          // Hit flag.
  input wire logic [3:0]              hit_line_r      // Hit line.
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // Bus answer checks.
  chk_ready_two_late: assert property (psel && !penable |-> ##2 pready)
    else $error("ready not two cycles after setup");
  chk_ready_one_wide: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_unmapped_err: assert property (psel && !penable && paddr > 8'h28 |-> ##2 pslverr)
    else $error("no error on unmapped address");
  chk_rdata_hold: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("read data moved outside a read");
  chk_lru_shown: assert property ((psel && !penable && !pwrite && paddr == pcache_pkg::OFF_LRU)
    ##2 pready |-> prdata[24:0] == lru_state) else $error("LRU read wrong");
  chk_protect_blank: assert property ((psel && !penable && !pwrite && code_protect &&
    paddr >= pcache_pkg::OFF_WORD0 && paddr <= pcache_pkg::OFF_WORD3) ##2 pready
    |-> prdata == 32'h0000_0000) else $error("protected word readable");
  // ==========================================================================
  // Hit flag checks.
  chk_nonc_no_hit: assert property (cpu_acc.valid && !cpu_acc.cacheable |=> !hit_r)
    else $error("hit on non-cacheable access");
  chk_idle_no_hit: assert property (!cpu_acc.valid |=> !hit_r)
    else $error("hit without access");
  cov_hit: cover property (hit_r);
  cov_err: cover property (pslverr);
  cov_abort: cover property (prefetch_abort);
endmodule : pcache_line_stats_checker

bind pcache_line_stats pcache_line_stats_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_acc(cpu_acc),
  .prefetch_abort(prefetch_abort), .code_protect(code_protect), .lru_state(lru_state),
  .hit_r(hit_r), .hit_line_r(hit_line_r));

//--- bench/test_prefetch_cache_line_access_stats.sv
// Self-checking bench for the cache line access and statistics block.
// Assumes the checker is bound and the processor model drives accesses.
`timescale 1ns/10ps
module test_prefetch_cache_line_access_stats;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, code_protect;
  logic prefetch_abort, hit_r;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] hit_line_r;
  logic [24:0] lru_state;
  logic [31:0] seed = 32'h0000_0029;
  logic [31:0] w[4];
  logic [32:0] expq[$];
  logic [32:0] e;
  logic [4:0] hitq[$];
  logic [4:0] h;
  logic acc_seen = 1'b0;
  pcache_pkg::cpu_access_t cpu_acc;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  // ==========================================================================
  // Design and processor model.
  pcache_line_stats u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_acc(cpu_acc), .prefetch_abort(prefetch_abort),
    .code_protect(code_protect), .lru_state(lru_state), .hit_r(hit_r),
    .hit_line_r(hit_line_r));
  pcache_cpu_model u_cpu (.pclk(pclk), .cpu_acc(cpu_acc), .prefetch_abort(prefetch_abort));
  // Random source.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Compare and count.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One bus transfer, held until ready is sampled high.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  // Read with the expected error flag and data noted first.
  task automatic rd(input logic [7:0] a, input logic [32:0] x);
    expq.push_back(x);
    xfer(1'b0, a, 32'h0000_0000);
  endtask : rd
  // One processor access with its expected hit flag and hit line noted first.
  task automatic access(input logic f, input logic c, input logic [19:0] t,
                        input logic [4:0] x);
    hitq.push_back(x);
    u_cpu.acc(f, c, t);
  endtask : access
  // Verdict.
  task automatic summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  // Clock.
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Read monitor takes the oldest note when read data appears.
  always @(posedge pclk)
  begin
    if (presetn && pready === 1'b1 && pwrite === 1'b0)
    begin
      e = expq.pop_front();
      chk({31'h0, pslverr}, {31'h0, e[32]});
      if (!e[32]) chk(prdata, e[31:0]);
    end
  end
  // Hit monitor takes the oldest note one clock after each processor access.
  always @(posedge pclk)
  begin
    if (acc_seen)
    begin
      h = hitq.pop_front();
      chk({27'h0, hit_r, hit_line_r}, {27'h0, h});
    end
    acc_seen <= cpu_acc.valid;
  end
  // Hang guard.
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      summarize();
    end
  end
  // Main sequence.
  initial
  begin
    {presetn, psel, penable, pwrite, code_protect} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    lru_state = 25'(rnd());
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(pcache_pkg::OFF_ACCESS, 33'h0);
    rd(pcache_pkg::OFF_MASK, 33'h0);
    xfer(1'b1, pcache_pkg::OFF_LRU, {7'h00, ~lru_state});
    rd(pcache_pkg::OFF_LRU, {8'h00, lru_state});
    xfer(1'b1, pcache_pkg::OFF_ACCESS, 32'h8000_0003);
    xfer(1'b1, pcache_pkg::OFF_MASK, 32'h0000_ffe0);
    rd(pcache_pkg::OFF_MASK, 33'h0);
    for (int i = 0; i < 4; i++)
    begin
      w[i] = rnd();
      xfer(1'b1, pcache_pkg::OFF_WORD0 + 8'(4 * i), w[i]);
    end
    for (int i = 0; i < 4; i++) rd(pcache_pkg::OFF_WORD0 + 8'(4 * i), {1'b0, w[i]});
    code_protect <= 1'b1;
    rd(pcache_pkg::OFF_WORD2, 33'h0);
    code_protect <= 1'b0;
    xfer(1'b1, pcache_pkg::OFF_ACCESS, 32'h0000_0003);
    xfer(1'b1, pcache_pkg::OFF_WORD0, ~w[0]);
    rd(pcache_pkg::OFF_WORD0, {1'b0, w[0]});
    xfer(1'b1, pcache_pkg::OFF_ACCESS, 32'h8000_0000);
    xfer(1'b1, pcache_pkg::OFF_TAG, {8'h00, 20'h12345, 4'h8});
    xfer(1'b1, pcache_pkg::OFF_ACCESS, 32'h8000_000a);
    xfer(1'b1, pcache_pkg::OFF_TAG, {8'h00, 20'h0abcd, 4'h8});
    xfer(1'b1, pcache_pkg::OFF_MASK, 32'h0000_ffe0);
    rd(pcache_pkg::OFF_MASK, 33'h0_0000_ffe0);
    xfer(1'b1, pcache_pkg::OFF_ACCESS, 32'h8000_0005);
    xfer(1'b1, pcache_pkg::OFF_TAG, {8'h00, 20'h55555, 4'h0});
    xfer(1'b1, pcache_pkg::OFF_HIT, 32'hffff_fffe);
    xfer(1'b1, pcache_pkg::OFF_MISS, 32'hffff_ffff);
    xfer(1'b1, pcache_pkg::OFF_ABORT, 32'hffff_ffff);
    rd(pcache_pkg::OFF_HIT, 33'h0_ffff_fffe);
    access(1'b1, 1'b1, 20'h12345, 5'h10);
    access(1'b0, 1'b1, 20'h12345, 5'h10);
    access(1'b1, 1'b1, 20'h0abcd ^ 20'hffe00, 5'h1a);
    access(1'b1, 1'b1, 20'h77777, 5'h00);
    access(1'b0, 1'b1, 20'h77777, 5'h00);
    access(1'b1, 1'b0, 20'h12345, 5'h00);
    access(1'b0, 1'b0, 20'h12345, 5'h00);
    access(1'b1, 1'b1, 20'h55555, 5'h00);
    u_cpu.abort_pf();
    u_cpu.abort_pf();
    rd(pcache_pkg::OFF_HIT, 33'h1);
    rd(pcache_pkg::OFF_MISS, 33'h1);
    rd(pcache_pkg::OFF_ABORT, 33'h1);
    rd(8'h2c, 33'h1_0000_0000);
    summarize();
  end
endmodule : test_prefetch_cache_line_access_stats

//--- shared/pcache_pkg.sv
// Package for the prefetch cache line access and statistics block.
// Assumes an APB slave with 32-bit data and one aligned word per register.
package pcache_pkg;
  // ==========================================================================
  // Register byte offsets.
  localparam logic [7:0] OFF_ACCESS   = 8'h00;
  localparam logic [7:0] OFF_TAG      = 8'h04;
  localparam logic [7:0] OFF_MASK     = 8'h08;
  localparam logic [7:0] OFF_WORD0    = 8'h0c;
  localparam logic [7:0] OFF_WORD1    = 8'h10;
  localparam logic [7:0] OFF_WORD2    = 8'h14;
  localparam logic [7:0] OFF_WORD3    = 8'h18;
  localparam logic [7:0] OFF_LRU      = 8'h1c;
  localparam logic [7:0] OFF_HIT      = 8'h20;
  localparam logic [7:0] OFF_MISS     = 8'h24;
  localparam logic [7:0] OFF_ABORT    = 8'h28;
  // ==========================================================================
  // Geometry and field positions.
  localparam int LINES      = 16;
  localparam int IDX_W      = 4;
  localparam int TAG_W      = 20;
  localparam int MASK_W     = 11;
  localparam int LRU_W      = 25;
  localparam int WEN_BIT    = 31;
  localparam int TAG_LSB    = 4;
  localparam int VALID_BIT  = 3;
  localparam int MASK_LSB   = 5;
  localparam logic [IDX_W-1:0] MASK_LINE_A = 4'ha;
  localparam logic [IDX_W-1:0] MASK_LINE_B = 4'hb;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [31:0] ONE32  = 32'h0000_0001;
  // ==========================================================================
  // Processor access event bundle.
  typedef struct packed {
    logic              valid;      // An access is presented this cycle.
    logic              is_fetch;   // Instruction fetch, else data load.
    logic              cacheable;  // Address lies in a cacheable region.
    logic [TAG_W-1:0]  addr_tag;   // Physical address bits 23:4.
  } cpu_access_t;
  // Line tag entry.
  typedef struct packed {
    logic              valid;
    logic [TAG_W-1:0]  tag;
  } line_tag_t;
endpackage : pcache_pkg

//--- verilog/pcache_line_stats.sv
// Top of the prefetch cache line access and statistics block.
// Assumes an APB master, a processor access bundle and a prefetch abort pulse.
//
// How it works
// - Set mask bits force matching tag bits to compare equal against the address.
// - The mask register is only writable while the selected line is 0x0a or 0x0b.
// - Four word registers read and write words 0 to 3 of the selected line.
// - The word registers read back zero while the chip is code-protected.
// - The 25-bit pseudo-LRU state is readable and the bits above read zero.
// - The hit counter counts cacheable fetches and loads that hit.
// - The miss counter counts cacheable instruction fetches that miss.
// - Non-cacheable accesses leave the hit and miss counters alone.
// - The abort counter counts every abandoned automatic prefetch.
// - The hit counter is read-write and is not reset.
// - Tag, mask and word writes take effect only while line write enable is set.
// - Only valid lines take part in hit detection on the 20-bit tag.
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/10ps
module pcache_line_stats
(
  input  wire logic                     pclk,          // System clock, 20 MHz.
  input  wire logic                     presetn,       // Asynchronous reset, low.
  input  wire logic                     psel,          // APB select.
  input  wire logic                     penable,       // APB enable.
  input  wire logic                     pwrite,        // APB direction.
  input  wire logic [7:0]               paddr,         // APB byte address.
  input  wire logic [31:0]              pwdata,        // APB write data.
  output logic      [31:0]              prdata,        // APB read data.
  output logic                          pready,        // APB ready.
  output logic                          pslverr,       // APB error.
  input  wire pcache_pkg::cpu_access_t  cpu_acc,       // Processor access.
  input  wire logic                     prefetch_abort,// Prefetch abandoned pulse.
  input  wire logic                     code_protect,  // Chip is code-protected.
  input  wire logic [24:0]              lru_state,     // Pseudo-LRU state.
  output logic                          hit_r,         // Registered hit result.
  output logic [3:0]                    hit_line_r     // Registered hit line.
);
  // ==========================================================================
  // Bus decode and registers.
  logic                                  wen_r;
  logic [pcache_pkg::IDX_W-1:0]          idx_r;
  pcache_pkg::line_tag_t                 tags_r [pcache_pkg::LINES];
  logic [pcache_pkg::MASK_W-1:0]         mask_a_r;
  logic [pcache_pkg::MASK_W-1:0]         mask_b_r;
  logic [31:0]                           hit_cnt;
  logic [31:0]                           miss_cnt;
  logic [31:0]                           abort_cnt;
  logic [31:0]                           mem_rdata;
  logic                                  setup;
  logic                                  wr_acc;
  logic                                  rd_pend_r;
  logic                                  word_sel;
  logic [1:0]                            word_idx;
  logic                                  mem_we;
  logic [pcache_pkg::LINES-1:0]          match;
  logic                                  any_hit;
  logic [3:0]                            hit_idx;
  logic [31:0]                           rd_mux;
  logic                                  rsp_now;
  logic                                  hit_event;
  logic                                  miss_event;

  assign setup    = psel && !penable;
  assign wr_acc   = psel && penable && pready && pwrite;
  assign word_sel = (paddr >= pcache_pkg::OFF_WORD0) && (paddr <= pcache_pkg::OFF_WORD3)
                    && (paddr[1:0] == 2'h0);
  assign word_idx = 2'((paddr - pcache_pkg::OFF_WORD0) >> 2);
  assign mem_we   = wr_acc && word_sel && wen_r;

  // Access phase one clock after setup; pready, prdata and pslverr all launch here.
  assign rsp_now  = rd_pend_r && psel && penable && !pready;

  // Data array for the line word window. Its read port follows the index and word
  // address every cycle, so data fetched after setup stand ready in the access phase.
  pcache_word_mem u_mem
  (
    .pclk  (pclk),
    .we    (mem_we),
    .waddr ({idx_r, word_idx}),
    .wdata (pwdata),
    .raddr ({idx_r, word_idx}),
    .rdata (mem_rdata)
  );

  // ==========================================================================
  // APB handshake.
  // Pready rises two cycles after setup so the array read has landed.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_pend_r <= 1'b0;
      pready    <= 1'b0;
    end
    else
    begin
      rd_pend_r <= setup;
      pready    <= rsp_now;
    end
  end

  // Access control register: write enable and line index.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wen_r <= 1'b0;
      idx_r <= '0;
    end
    else if (wr_acc && paddr == pcache_pkg::OFF_ACCESS)
    begin
      wen_r <= pwdata[pcache_pkg::WEN_BIT];
      idx_r <= pwdata[pcache_pkg::IDX_W-1:0];
    end
  end

  // ==========================================================================
  // Line tag and mask registers.
  // Tag register per line, writable only with line write enable.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < pcache_pkg::LINES; i++)
      begin
        tags_r[i] <= '0;
      end
    end
    else if (wr_acc && paddr == pcache_pkg::OFF_TAG && wen_r)
    begin
      tags_r[idx_r].valid <= pwdata[pcache_pkg::VALID_BIT];
      tags_r[idx_r].tag   <= pwdata[pcache_pkg::TAG_LSB +: pcache_pkg::TAG_W];
    end
  end

  // Mask registers exist only for the two maskable lines.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_a_r <= '0;
      mask_b_r <= '0;
    end
    else if (wr_acc && paddr == pcache_pkg::OFF_MASK && wen_r)
    begin
      if (idx_r == pcache_pkg::MASK_LINE_A)
      begin
        mask_a_r <= pwdata[pcache_pkg::MASK_LSB +: pcache_pkg::MASK_W];
      end
      else if (idx_r == pcache_pkg::MASK_LINE_B)
      begin
        mask_b_r <= pwdata[pcache_pkg::MASK_LSB +: pcache_pkg::MASK_W];
      end
    end
  end

  // ==========================================================================
  // Hit detection over all lines.
  generate
    for (genvar g = 0; g < pcache_pkg::LINES; g++)
    begin : g_cmp
      // Mask bits cover the top eleven tag bits; the low nine always compare.
      logic [pcache_pkg::TAG_W-1:0] force_eq;
      if (g == 10)
      begin : g_ma
        assign force_eq = {mask_a_r, 9'h000};
      end
      else if (g == 11)
      begin : g_mb
        assign force_eq = {mask_b_r, 9'h000};
      end
      else
      begin : g_nm
        assign force_eq = '0;
      end
      // Only valid lines compare; masked bits always agree.
      assign match[g] = tags_r[g].valid
                        && (((tags_r[g].tag ^ cpu_acc.addr_tag) & ~force_eq) == '0);
    end
  endgenerate

  // Lowest matching line wins.
  always_comb
  begin
    any_hit = 1'b0;
    hit_idx = 4'h0;
    for (int i = pcache_pkg::LINES - 1; i >= 0; i--)
    begin
      if (match[i])
      begin
        any_hit = 1'b1;
        hit_idx = 4'(i);
      end
    end
  end

  // Qualified processor events; non-cacheable accesses never reach the counters.
  assign hit_event  = cpu_acc.valid && cpu_acc.cacheable && any_hit;
  assign miss_event = cpu_acc.valid && cpu_acc.cacheable && cpu_acc.is_fetch
                      && !any_hit;

  // Registered hit result for the rest of the cache.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hit_r      <= 1'b0;
      hit_line_r <= 4'h0;
    end
    else
    begin
      hit_r      <= hit_event;
      hit_line_r <= hit_idx;
    end
  end

  // ==========================================================================
  // Statistics counters; not reset, software loads them.
  pcache_stat_counter u_hit
  (
    .pclk     (pclk),
    .load     (wr_acc && paddr == pcache_pkg::OFF_HIT),
    .load_val (pwdata),
    .inc      (hit_event),
    .count_r  (hit_cnt)
  );

  pcache_stat_counter u_miss
  (
    .pclk     (pclk),
    .load     (wr_acc && paddr == pcache_pkg::OFF_MISS),
    .load_val (pwdata),
    .inc      (miss_event),
    .count_r  (miss_cnt)
  );

  pcache_stat_counter u_abort
  (
    .pclk     (pclk),
    .load     (wr_acc && paddr == pcache_pkg::OFF_ABORT),
    .load_val (pwdata),
    .inc      (prefetch_abort),
    .count_r  (abort_cnt)
  );

  // ==========================================================================
  // Read multiplexer.
  always_comb
  begin
    rd_mux = pcache_pkg::ZERO32;
    case (paddr)
      pcache_pkg::OFF_ACCESS: rd_mux = {wen_r, 27'h0, idx_r};
      pcache_pkg::OFF_TAG:    rd_mux = {8'h00, tags_r[idx_r].tag, tags_r[idx_r].valid, 3'h0};
      pcache_pkg::OFF_MASK:
      begin
        if (idx_r == pcache_pkg::MASK_LINE_A)
        begin
          rd_mux = {16'h0000, mask_a_r, 5'h00};
        end
        else if (idx_r == pcache_pkg::MASK_LINE_B)
        begin
          rd_mux = {16'h0000, mask_b_r, 5'h00};
        end
      end
      pcache_pkg::OFF_WORD0,
      pcache_pkg::OFF_WORD1,
      pcache_pkg::OFF_WORD2,
      pcache_pkg::OFF_WORD3:  rd_mux = code_protect ? pcache_pkg::ZERO32 : mem_rdata;
      pcache_pkg::OFF_LRU:    rd_mux = {7'h00, lru_state};
      pcache_pkg::OFF_HIT:    rd_mux = hit_cnt;
      pcache_pkg::OFF_MISS:   rd_mux = miss_cnt;
      pcache_pkg::OFF_ABORT:  rd_mux = abort_cnt;
      default:                rd_mux = pcache_pkg::ZERO32;
    endcase
  end

  // Read data are captured on reads only, so a write leaves the last read value standing.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= pcache_pkg::ZERO32;
    end
    else if (rsp_now && !pwrite)
    begin
      prdata <= rd_mux;
    end
  end

  // Unmapped or unaligned addresses answer with pslverr alongside pready.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pslverr <= 1'b0;
    end
    else
    begin
      pslverr <= rsp_now
                 && ((paddr > pcache_pkg::OFF_ABORT) || (paddr[1:0] != 2'h0));
    end
  end
endmodule : pcache_line_stats

//--- verilog/pcache_stat_counter.sv
// A 32-bit statistics counter, software loadable, counting one event a cycle.
// Assumes event pulses synchronous to pclk.
`timescale 1ns/10ps
module pcache_stat_counter
(
  input  wire logic        pclk,     // System clock.
  input  wire logic        load,     // Software write strobe.
  input  wire logic [31:0] load_val, // Value written by software.
  input  wire logic        inc,      // Qualifying event.
  output logic      [31:0] count_r   // Current count.
);
  // Software load has priority; otherwise count and wrap silently.
  always_ff @(posedge pclk)
  begin
    if (load)
    begin
      count_r <= load_val;
    end
    else if (inc)
    begin
      count_r <= count_r + pcache_pkg::ONE32;
    end
  end
endmodule : pcache_stat_counter

//--- verilog/pcache_word_mem.sv
// Little memory holding the four data words of every cache line.
// Assumes one write port and a registered read port on pclk.
`timescale 1ns/10ps
module pcache_word_mem
(
  input  wire logic        pclk,     // System clock.
  input  wire logic        we,       // Write strobe.
  input  wire logic [5:0]  waddr,    // Write address, line and word.
  input  wire logic [31:0] wdata,    // Write data.
  input  wire logic [5:0]  raddr,    // Read address, line and word.
  output logic      [31:0] rdata     // Registered read data.
);
  logic [31:0] mem_r [0:63];

  // Write and registered read; contents are undefined after reset.
  always_ff @(posedge pclk)
  begin
    if (we)
    begin
      mem_r[waddr] <= wdata;
    end
    rdata <= mem_r[raddr];
  end
endmodule : pcache_word_mem
